// >>> rtl/bafc_pkg.sv
// bafc_pkg: shared constants and carrier types for the blit output stage
// assumes a 16-bit destination word path and a single core clock
package bafc_pkg;
  // word geometry
  localparam int unsigned WORD_W        = 16;
  // control word two field positions
  localparam int unsigned CW2_DESC_BIT  = 1;
  localparam int unsigned CW2_SEED_BIT  = 2;
  localparam int unsigned CW2_INCL_BIT  = 3;
  localparam int unsigned CW2_EXCL_BIT  = 4;
  localparam logic [15:0] CW2_RESET     = 16'h0000;
  // transfer size register layout: words per row low 6 bits, rows above
  localparam int unsigned SIZE_W_LSB    = 0;
  localparam int unsigned SIZE_W_BITS   = 6;
  localparam int unsigned SIZE_H_LSB    = 6;
  localparam int unsigned SIZE_H_BITS   = 10;
  // readback bit position of the busy flag
  localparam int unsigned BUSY_BIT_IDX  = 14;
  // fifo depth default
  localparam int unsigned FIFO_DEPTH    = 4;

  // one combined destination word entering the fill stage
  typedef struct packed {
    logic [WORD_W-1:0] data;   // after shift, mask and logic function
    logic              last;   // leftmost word of a row
  } bafc_word_s;

  // fill mode decode
  typedef enum logic [1:0] {
    BAFC_FILL_OFF,
    BAFC_FILL_INCL,
    BAFC_FILL_EXCL
  } bafc_fill_e;
endpackage : bafc_pkg

// >>> rtl/bafc_fifo.sv
// bafc_fifo: holds no logic; the word buffer module bafc_fifo sits at the
// foot of bafc_fill.sv so that the whole output stage is one design file

// >>> rtl/bafc_fill.sv
// bafc_fill: area fill output stage and completion reporting of a blit
// engine. receives combined destination words (already shifted, masked
// and passed through the logic function), fills them row by row, and
// reports busy/finished. the small word buffer module sits at the foot
// of this file. assumes the word producer and memory writer live outside
// and use valid/ready; single core clock, asynchronous active-low reset.
`timescale 1ns/1ps
module bafc_fill
  import bafc_pkg::*;
#(
  parameter int unsigned DEPTH = bafc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // host register writes
  input  wire logic                    cw2_wr,
  input  wire logic [15:0]             cw2_wdata,
  input  wire logic                    transfer_size_register_wr,
  input  wire logic [15:0]             transfer_size_register_wdata,
  input  wire logic                    finished_clr,
  // status to host
  output logic [15:0]                  dma_control_readback,
  output logic                         transfer_busy_flag,
  output logic                         transfer_finished_interrupt,
  output logic [15:0]                  blit_control_word_two,
  // combined word input from logic-function stage
  input  wire logic                    src_valid,
  output logic                         src_ready,
  input  wire bafc_pkg::bafc_word_s    src_word,
  // filled destination word out to memory writer
  output logic                         dst_valid,
  input  wire logic                    dst_ready,
  output logic [bafc_pkg::WORD_W-1:0]  dst_data
);
  import bafc_pkg::*;

  // field widths of the size register; the word counters span both
  localparam int unsigned SW = bafc_pkg::SIZE_W_BITS;  // words per row
  localparam int unsigned SH = bafc_pkg::SIZE_H_BITS;  // rows

  // engine state
  typedef enum logic [0:0] {
    BAFC_IDLE,
    BAFC_RUN
  } bafc_state_e;

  bafc_state_e      st_q, st_d;     // engine state
  logic [15:0]      cw2_q;          // control word two
  logic [SW+SH:0]   left_q;         // destination words still to come
  logic             fill_q;         // fill state carried between words
  logic             done_q;         // sticky finished flag
  logic             in_row_q;       // a row is under way
  logic [WORD_W-1:0] out_q;         // filled word register
  logic             out_v_q;        // filled word waiting
  // wide enough for the largest size, every row of every column
  logic [SW+SH:0]   owe_q;          // words not yet taken by the writer
  logic             busy;           // transfer in progress

  // mode decode from control word two
  wire desc_mode = cw2_q[CW2_DESC_BIT];
  wire incl_en   = cw2_q[CW2_INCL_BIT];
  wire excl_en   = cw2_q[CW2_EXCL_BIT];
  wire seed      = cw2_q[CW2_SEED_BIT];  // state at each row's right edge
  // fills are only defined walking right to left, so an ascending
  // transfer passes words through unfilled; exclusive beats inclusive
  wire bafc_fill_e mode = !desc_mode ? BAFC_FILL_OFF  :
                          excl_en    ? BAFC_FILL_EXCL :
                          incl_en    ? BAFC_FILL_INCL : BAFC_FILL_OFF;

  // size decode; zero fields mean the full range
  wire [SW-1:0] sz_w = transfer_size_register_wdata[SIZE_W_LSB +: SW];
  wire [SH-1:0] sz_h = transfer_size_register_wdata[SIZE_H_LSB +: SH];
  wire [SW:0]   w_n  = (sz_w == '0) ? (SW+1)'(1 << SW) : {1'b0, sz_w};
  wire [SH:0]   h_n  = (sz_h == '0) ? (SH+1)'(1 << SH) : {1'b0, sz_h};
  wire [SW+SH+1:0] total = (SW+SH+2)'(w_n) * (SW+SH+2)'(h_n);

  // fill one full word from right to left; returns word and carry out.
  // a boundary bit toggles the state; inclusive ors the boundary back in,
  // exclusive uses the state after the toggle so left edges drop out.
  function automatic logic [WORD_W:0] fill_word(
    input logic [WORD_W-1:0] w,
    input logic              cin,
    input bafc_fill_e        m
  );
    logic [WORD_W-1:0] r;
    logic              s;
    r = '0;
    s = cin;
    for (int i = 0; i < WORD_W; i++) begin
      s    = s ^ w[i];
      r[i] = (m == BAFC_FILL_INCL) ? (s | w[i]) : s;
    end
    return {s, r};
  endfunction : fill_word

  // row start loads seed, otherwise carry from the word to the right
  wire              row_cin  = in_row_q ? fill_q : seed;
  wire [WORD_W:0]   filled   = fill_word(src_word.data, row_cin, mode);
  // fill sits last, after all source combination upstream
  wire [WORD_W-1:0] fill_out = (mode == BAFC_FILL_OFF) ? src_word.data
                                                        : filled[WORD_W-1:0];

  // handshake: one output slot, drained by the fifo
  logic fifo_in_ready;                                  // buffer has room
  wire  take     = (st_q == BAFC_RUN) && src_valid && src_ready;
  wire  slot_go  = out_v_q && fifo_in_ready;            // slot moves on
  // words are refused outside a transfer; a stalled writer backs up here
  assign src_ready = (st_q == BAFC_RUN) && (!out_v_q || fifo_in_ready);
  wire  last_word = take && (left_q == (SW+SH+1)'(1));  // leftmost, last row
  // a word leaving the buffer for memory; the final one ends the transfer
  wire  pop_out   = dst_valid && dst_ready;
  wire  fin       = pop_out && (owe_q == (SW+SH+1)'(1));
  // a size write while words still drain would corrupt the count: ignored
  wire  start     = transfer_size_register_wr && !busy;

  // next state
  // run ends at the last take; draining afterwards is counted by owe_q
  always_comb begin
    st_d = st_q;
    case (st_q)
      BAFC_IDLE: if (start) st_d = BAFC_RUN;
      BAFC_RUN:  if (last_word) st_d = BAFC_IDLE;
      default:   st_d = BAFC_IDLE;
    endcase
  end

  // state, counters and control register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q   <= BAFC_IDLE;
      cw2_q  <= CW2_RESET;
      left_q <= '0;
    end else begin
      st_q <= st_d;
      // writes while busy are the host's fault; ignored here, which also
      // keeps the mode steady while queued words still drain
      if (cw2_wr && !busy) cw2_q <= cw2_wdata;
      if (start) left_q <= total[SW+SH:0];
      else if (take) left_q <= left_q - (SW+SH+1)'(1);
    end
  end

  // fill state carried along the row; the seed takes over at each row start
  // last marks the leftmost word, so the word after it opens a new row
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fill_q   <= 1'b0;
      in_row_q <= 1'b0;
    end else if (take) begin
      fill_q   <= filled[WORD_W];
      in_row_q <= !src_word.last;
    end else if (start) begin
      in_row_q <= 1'b0;
    end
  end

  // output word register in front of the fifo
  // one word of slack keeps the fill logic off the fifo's write path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_q   <= '0;
      out_v_q <= 1'b0;
    end else begin
      if (take) out_q <= fill_out;
      out_v_q <= take | (out_v_q & !slot_go);
    end
  end

  // words owed to memory; busy lasts until the writer has the final word,
  // so the host may use results as soon as busy reads low. start and a
  // pop never meet, since start needs an empty buffer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      owe_q <= '0;
    end else if (start) begin
      owe_q <= total[SW+SH:0];
    end else if (pop_out) begin
      owe_q <= owe_q - (SW+SH+1)'(1);
    end
  end

  // sticky finished flag: set beats clear, mask lives elsewhere
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) done_q <= 1'b0;
    else if (fin) done_q <= 1'b1;
    else if (finished_clr) done_q <= 1'b0;
  end

  // busy rises straight off the size write, no wait for memory grant,
  // and covers words still queued for the writer
  assign busy = (owe_q != '0);
  assign transfer_busy_flag = busy;
  assign transfer_finished_interrupt = done_q;
  assign blit_control_word_two = cw2_q;
  // readback shows busy at its bit, other bits zero here
  assign dma_control_readback =
    16'(transfer_busy_flag) << BUSY_BIT_IDX;

  // destination fifo; stall of the writer reaches src_ready
  bafc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (out_v_q),
    .in_ready  (fifo_in_ready),
    .in_data   (out_q),
    .out_valid (dst_valid),
    .out_ready (dst_ready),
    .out_data  (dst_data)
  );
endmodule : bafc_fill

// bafc_fifo: small flip-flop fifo with valid/ready on both sides.
// a level counter keeps full and empty exact for any depth, at the cost
// of a few more flops than comparing pointers with a wrap bit.
// stored data is not reset, so out_data means nothing while out_valid is
// low. one clock; reset clears only the indices and the level.
// both ready and valid come straight from the level register.
module bafc_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // index width; a depth of one still needs one bit
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW-1:0]    wr_q;           // write index
  logic [AW-1:0]    rd_q;           // read index
  logic [AW:0]      cnt_q;          // fill level

  // transfers on each side
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // honest flags from the level counter
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // index wrap for non power of two depths
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction : bump

  // pointers and level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= bump(wr_q);
      if (pop)  rd_q <= bump(rd_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule : bafc_fifo

// >>> tb/bafc_fill_monitor.sv
// bafc_fill_monitor: port-level checks of the blit fill output stage
// assumes one core clock and the bind at the foot of this file
`timescale 1ns/1ps
module bafc_fill_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // host side
  input wire logic        cw2_wr,
  input wire logic [15:0] cw2_wdata,
  input wire logic        transfer_size_register_wr,
  input wire logic        finished_clr,
  input wire logic [15:0] dma_control_readback,
  input wire logic        transfer_busy_flag,
  input wire logic        transfer_finished_interrupt,
  input wire logic [15:0] blit_control_word_two,
  // streams
  input wire logic        src_ready,
  input wire logic        dst_valid,
  input wire logic        dst_ready,
  input wire logic [15:0] dst_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // busy must rise on the edge right after an idle size write
  a_busy_on_size: assert property (transfer_size_register_wr &&
    !transfer_busy_flag |=> transfer_busy_flag)
    else $error("busy did not follow size write");
  a_readback_busy: assert property (dma_control_readback ===
    {1'b0, transfer_busy_flag, 14'h0000})
    else $error("readback does not mirror busy");
  a_flag_on_done: assert property ($fell(transfer_busy_flag) |->
    transfer_finished_interrupt)
    else $error("finished flag missing at completion");
  a_flag_stays_set: assert property (transfer_finished_interrupt &&
    !finished_clr |=> transfer_finished_interrupt)
    else $error("finished flag dropped without clear");
  a_cw2_write_held: assert property (cw2_wr && transfer_busy_flag |=>
    $stable(blit_control_word_two))
    else $error("control word changed while busy");
  a_cw2_write_load: assert property (cw2_wr && !transfer_busy_flag |=>
    blit_control_word_two == $past(cw2_wdata))
    else $error("control word not loaded");
  a_idle_no_take: assert property (!transfer_busy_flag |-> !src_ready
    && !dst_valid)
    else $error("stream active while idle");
  a_dst_hold_data: assert property (dst_valid && !dst_ready |=>
    dst_valid && $stable(dst_data))
    else $error("output word not held under stall");
  // main scenarios seen
  c_flag_clear: cover property (transfer_finished_interrupt && finished_clr);
  c_dst_stall: cover property (dst_valid && !dst_ready);
  c_done: cover property ($fell(transfer_busy_flag));
endmodule : bafc_fill_monitor

bind bafc_fill bafc_fill_monitor u_mon (
  .core_clk(core_clk), .rstn(rstn), .cw2_wr(cw2_wr),
  .cw2_wdata(cw2_wdata), .finished_clr(finished_clr),
  .transfer_size_register_wr(transfer_size_register_wr),
  .dma_control_readback(dma_control_readback),
  .transfer_busy_flag(transfer_busy_flag),
  .transfer_finished_interrupt(transfer_finished_interrupt),
  .blit_control_word_two(blit_control_word_two), .src_ready(src_ready),
  .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data));

// >>> tb/bafc_mem_model.sv
// bafc_mem_model: memory writer taking filled words, may stall
// assumes the bench collects accepted words itself
`timescale 1ns/1ps
module bafc_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control from bench
  input wire logic stall,
  // word stream
  output logic     dst_ready
);
  logic [1:0] cnt_q; // stall phase counter
  // free-running phase so stalls land on varied words
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // stalled: accept one cycle in four only
  assign dst_ready = !stall || (cnt_q == 2'h3);
endmodule : bafc_mem_model

// >>> tb/test_blit_area_fill_and_completion.sv
// test_blit_area_fill_and_completion: directed bench of the fill stage
// assumes bafc_fill, bafc_fifo and the memory writer model
`timescale 1ns/1ps
module test_blit_area_fill_and_completion;
  import bafc_pkg::*;
  logic core_clk = 0, rstn = 0, cw2_wr = 0, tsr_wr = 0, fclr = 0;
  logic src_valid = 0, stall = 0, src_ready, dst_valid, dst_ready;
  logic [15:0] cw2_wdata = 16'h0000, tsr_wdata = 16'h0000, rb, cw2, dst_data;
  logic busy, flag;
  bafc_word_s src_word = '0;
  logic [15:0] wd [16]; // words of next transfer, right to left
  logic [15:0] got_q [$]; // words taken by the memory writer
  int num_errors = 0, check_count = 0;
  always #12.5 core_clk = ~core_clk;
  bafc_fill #(.DEPTH(4)) u_dut (.core_clk(core_clk), .rstn(rstn),
    .cw2_wr(cw2_wr), .cw2_wdata(cw2_wdata), .finished_clr(fclr),
    .transfer_size_register_wr(tsr_wr),
    .transfer_size_register_wdata(tsr_wdata),
    .dma_control_readback(rb), .transfer_busy_flag(busy),
    .transfer_finished_interrupt(flag), .blit_control_word_two(cw2),
    .src_valid(src_valid), .src_ready(src_ready), .src_word(src_word),
    .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data));
  bafc_mem_model u_mem (.core_clk(core_clk), .rstn(rstn), .stall(stall),
    .dst_ready(dst_ready));
  always @(posedge core_clk)
    if (dst_valid && dst_ready) got_q.push_back(dst_data);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // reference fill: state toggles per one bit, lsb first
  function automatic logic [15:0] fillw(input logic [15:0] w,
      input logic [15:0] cw, inout logic s);
    logic [15:0] o;
    o = w;
    for (int i = 0; i < 16; i++) begin
      if (cw[4]) begin
        s ^= w[i];
        o[i] = s;
      end else if (cw[3]) begin
        o[i] = s | w[i];
        s ^= w[i];
      end
    end
    return o;
  endfunction : fillw
  // one whole transfer, with a refused write in mid-run
  task automatic xfer(input logic [15:0] cw, input int wpr, input int rows);
    logic [15:0] e [$];
    logic s;
    int k;
    got_q = {};
    s = cw[2];
    @(posedge core_clk) #1 cw2_wr = 1;
    cw2_wdata = cw;
    @(posedge core_clk) #1 cw2_wr = 0;
    tsr_wr = 1;
    tsr_wdata = {rows[9:0], wpr[5:0]};
    @(posedge core_clk) #1 tsr_wr = 0;
    chk(rb, 16'h4000);
    cw2_wr = 1;
    cw2_wdata = ~cw;
    @(posedge core_clk) #1 cw2_wr = 0;
    chk(cw2, cw);
    for (int i = 0; i < wpr * rows; i++) begin
      src_valid = 1;
      // words stand for a cookie-cut copy with zero shift, mask all ones
      src_word.data = wd[i];
      src_word.last = (i % wpr == wpr - 1);
      e.push_back(fillw(wd[i], cw, s));
      if (src_word.last) s = cw[2];
      k = 0;
      while (!src_ready && k < 100) begin
        @(posedge core_clk) #1 k++;
      end
      chk({15'h0000, src_ready}, 16'h0001);
      @(posedge core_clk) #1;
    end
    src_valid = 0;
    k = 0;
    while (busy !== 1'b0 && k++ < 300) @(posedge core_clk) #1;
    chk({15'h0000, busy}, 16'h0000);
    chk(flag, 1'b1);
    chk(got_q.size(), e.size());
    foreach (e[i]) chk(got_q[i], e[i]);
    fclr = 1;
    @(posedge core_clk) #1 fclr = 0;
    chk(flag, 1'b0);
  endtask : xfer
  task automatic t_reset;
    chk({14'h0000, busy, flag}, 16'h0000);
    chk(rb, 16'h0000);
    chk(cw2, 16'h0000);
  endtask : t_reset
  // sample pattern, both modes, both seeds, plus no fill
  task automatic t_modes;
    logic [15:0] cws [5] = '{16'h000a, 16'h0012, 16'h000e, 16'h0016, 16'h0002};
    wd[0] = 16'h2418;
    foreach (cws[i]) xfer(cws[i], 1, 1);
  endtask : t_modes
  // state carries across words, then reloads per row
  task automatic t_row;
    wd[0] = 16'h0001;
    wd[1] = 16'h0000;
    wd[2] = 16'h8000;
    wd[3] = 16'h0000;
    xfer(16'h000a, 2, 2);
  endtask : t_row
  // writer stalls so the fifo fills and refuses
  task automatic t_buffer;
    foreach (wd[i]) wd[i] = 16'h0101 << (i % 8);
    stall = 1;
    xfer(16'h0012, 8, 2);
    stall = 0;
  endtask : t_buffer
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rstn = 1;
    t_reset();
    t_modes();
    t_row();
    t_buffer();
    close_out();
  end
  // watchdog well past the expected couple of hundred cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    close_out();
  end
endmodule : test_blit_area_fill_and_completion
